/* src/misu_core.sv */
// Execution logic for the miscellaneous system instructions.
// Assumes a decoded instruction word strobe from the CPU sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "misu_map.svh"

module misu_core
   import misu_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Instruction stream
   input wire logic instr_valid_in,
   input wire logic [9:0] instr_code_in,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] regb_in,
   // Flags from other blocks
   input wire logic conv_done_set_in,
   input wire logic conv_irq_enable_bit_in,
   input wire logic powerup_flag_in,
   input wire logic watchdog_flag_one_in,
   input wire logic backup_mode_in,
   input wire logic detector_enable_pin_in,
   // Write-back and sequencing
   output misu_wb_t wb_out,
   output logic skip_out,
   // Converter
   output logic conv_start_out,
   output logic conv_cmp_mode_out,
   output logic conv_done_flag_out,
   output logic [3:0] conv_ctrl_reg_a_out,
   output logic [3:0] conv_ctrl_reg_b_out,
   output logic [3:0] conv_ctrl_reg_c_out,
   // System control
   output logic power_off_req_out,
   output logic watchdog_flag_clear_out,
   output logic watchdog_stop_out,
   output logic sys_reset_req_out,
   output logic detector_active_out,
   output logic table_bank_bit_out,
   output logic [7:0] sio_out
);

   misu_op_t op;
   logic pin_meta;
   logic pin_sync;
   logic pofen_armed;
   logic wddis_armed;
   logic det_enabled;
   logic conv_done_flag;
   logic next_conv_done_flag;
   logic [3:0] conv_ctrl_reg_a;
   logic [3:0] conv_ctrl_reg_b;
   logic [3:0] conv_ctrl_reg_c;
   logic [7:0] sio;
   misu_wb_t next_wb;
   logic next_skip;

   // Decode one single-word instruction
   always_comb begin
      op = MISU_NONE;
      if (instr_valid_in) begin
         case (instr_code_in)
            `MISU_OP_NOP: op = MISU_NOP;
            `MISU_OP_SWRST: op = MISU_SWRST;
            `MISU_OP_PWROFF: op = MISU_PWROFF;
            `MISU_OP_PUTEST: op = MISU_PUTEST;
            `MISU_OP_POFEN: op = MISU_POFEN;
            `MISU_OP_WDSVC: op = MISU_WDSVC;
            `MISU_OP_WDDIS: op = MISU_WDDIS;
            `MISU_OP_DETEN: op = MISU_DETEN;
            `MISU_OP_BKRST: op = MISU_BKRST;
            `MISU_OP_BKSET: op = MISU_BKSET;
            `MISU_OP_SPLRD: op = MISU_SPLRD;
            `MISU_OP_SPLWR: op = MISU_SPLWR;
            `MISU_OP_RDQA: op = MISU_RDQA;
            `MISU_OP_WRQA: op = MISU_WRQA;
            `MISU_OP_RDQB: op = MISU_RDQB;
            `MISU_OP_WRQB: op = MISU_WRQB;
            `MISU_OP_RDQC: op = MISU_RDQC;
            `MISU_OP_WRQC: op = MISU_WRQC;
            `MISU_OP_CSTART: op = MISU_CSTART;
            `MISU_OP_CDTEST: op = MISU_CDTEST;
            default: op = MISU_NONE;
         endcase
      end
   end

   // Accumulator and B write-back, skip decisions
   always_comb begin
      next_wb = '0;
      next_skip = 1'b0;
      case (op)
         MISU_RDQA: begin
            next_wb.acc_load = 1'b1;
            next_wb.acc = conv_ctrl_reg_a;
         end
         MISU_RDQB: begin
            next_wb.acc_load = 1'b1;
            next_wb.acc = conv_ctrl_reg_b;
         end
         MISU_RDQC: begin
            next_wb.acc_load = 1'b1;
            next_wb.acc = conv_ctrl_reg_c;
         end
         MISU_SPLRD: begin
            next_wb.b_load = 1'b1;
            next_wb.b = sio[7:4];
            next_wb.acc_load = 1'b1;
            next_wb.acc = sio[3:0];
         end
         MISU_CDTEST: next_skip = !conv_irq_enable_bit_in && conv_done_flag;
         MISU_PUTEST: next_skip = powerup_flag_in;
         MISU_WDSVC: next_skip = watchdog_flag_one_in;
         default: next_skip = 1'b0; // No-operation falls here
      endcase
   end

   // Registered write-back and skip, one cycle after the instruction
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_out <= '0;
         skip_out <= 1'b0;
      end else begin
         wb_out <= next_wb;
         skip_out <= next_skip;
      end
   end

   // Conversion done flag; a hardware set wins over an instruction clear
   always_comb begin
      next_conv_done_flag = conv_done_flag;
      if (op == MISU_CSTART)
         next_conv_done_flag = 1'b0;
      if (op == MISU_CDTEST && !conv_irq_enable_bit_in && conv_done_flag)
         next_conv_done_flag = 1'b0;
      if (conv_done_set_in)
         next_conv_done_flag = 1'b1;
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in)
         conv_done_flag <= 1'b0;
      else
         conv_done_flag <= next_conv_done_flag;
   end

   // Conversion start pulse and mode
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         conv_start_out <= 1'b0;
         conv_cmp_mode_out <= 1'b0;
      end else begin
         conv_start_out <= (op == MISU_CSTART);
         if (op == MISU_CSTART)
            conv_cmp_mode_out <= conv_ctrl_reg_a[`MISU_MODE_BIT];
      end
   end

   // Converter control registers
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         conv_ctrl_reg_a <= `MISU_NIB_RST;
         conv_ctrl_reg_b <= `MISU_NIB_RST;
         conv_ctrl_reg_c <= `MISU_NIB_RST;
      end else begin
         if (op == MISU_WRQA)
            conv_ctrl_reg_a <= acc_in;
         if (op == MISU_WRQB)
            conv_ctrl_reg_b <= acc_in;
         if (op == MISU_WRQC)
            conv_ctrl_reg_c <= acc_in;
      end
   end

   // Split transfer register
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in)
         sio <= `MISU_SIO_RST;
      else if (op == MISU_SPLWR)
         sio <= {regb_in, acc_in};
   end

   // Two-step arming: any other instruction disarms
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pofen_armed <= 1'b0;
         wddis_armed <= 1'b0;
      end else if (instr_valid_in) begin
         pofen_armed <= (op == MISU_POFEN);
         wddis_armed <= (op == MISU_WDDIS);
      end
   end

   // Power-off, watchdog, reset requests
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         power_off_req_out <= 1'b0;
         watchdog_flag_clear_out <= 1'b0;
         sys_reset_req_out <= 1'b0;
      end else begin
         power_off_req_out <= (op == MISU_PWROFF) && pofen_armed;
         watchdog_flag_clear_out <= (op == MISU_WDSVC) && watchdog_flag_one_in;
         sys_reset_req_out <= (op == MISU_SWRST);
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in)
         watchdog_stop_out <= 1'b0;
      else if (op == MISU_WDSVC && wddis_armed)
         watchdog_stop_out <= 1'b1;
   end

   // Table bank bit
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in)
         table_bank_bit_out <= 1'b0;
      else if (op == MISU_BKRST)
         table_bank_bit_out <= 1'b0;
      else if (op == MISU_BKSET)
         table_bank_bit_out <= 1'b1;
   end

   // Detector enable pin synchroniser and gating
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         det_enabled <= 1'b0;
         detector_active_out <= 1'b0;
      end else begin
         pin_meta <= detector_enable_pin_in;
         pin_sync <= pin_meta;
         if (op == MISU_DETEN)
            det_enabled <= 1'b1;
         detector_active_out <= det_enabled && backup_mode_in && pin_sync;
      end
   end

   assign conv_done_flag_out = conv_done_flag;
   assign conv_ctrl_reg_a_out = conv_ctrl_reg_a;
   assign conv_ctrl_reg_b_out = conv_ctrl_reg_b;
   assign conv_ctrl_reg_c_out = conv_ctrl_reg_c;
   assign sio_out = sio;

   // Checks
   sequence s_pofen;
      op == MISU_POFEN;
   endsequence
   sequence s_poweroff_next;
      instr_valid_in && op == MISU_PWROFF;
   endsequence

   a_conv_start_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_CSTART && !conv_done_set_in |=> !conv_done_flag && conv_start_out)
      else $error("conversion start did not clear flag or pulse");
   a_done_skip: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_CDTEST |=> skip_out == $past(!conv_irq_enable_bit_in && conv_done_flag))
      else $error("done test skip wrong");
   a_reg_a_write: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_WRQA ##1 op == MISU_RDQA |=> wb_out.acc_load && wb_out.acc == $past(acc_in, 2))
      else $error("control register a readback wrong");
   a_nop_quiet: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_NOP |=> !skip_out && !wb_out.acc_load && !wb_out.b_load && $stable(sio))
      else $error("no-operation changed state");
   a_poweroff_pair: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      s_pofen ##1 s_poweroff_next |=> power_off_req_out)
      else $error("armed power-off not taken");
   a_poweroff_alone: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      power_off_req_out |-> $past(op == MISU_PWROFF) && $past(pofen_armed))
      else $error("power-off without arming");
   a_pu_skip: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_PUTEST |=> skip_out == $past(powerup_flag_in))
      else $error("power-up test skip wrong");
   a_wd_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_WDSVC && watchdog_flag_one_in |=> skip_out && watchdog_flag_clear_out)
      else $error("watchdog service skip or clear missing");
   a_wd_stop: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      $rose(watchdog_stop_out) |-> $past(op == MISU_WDSVC) && $past(wddis_armed))
      else $error("watchdog stopped without disable pair");
   a_det_gate: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      detector_active_out |-> $past(backup_mode_in) && $past(pin_sync))
      else $error("detector active outside back-up or pin low");
   a_bank_bits: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_BKSET ##1 op == MISU_BKRST |=> !table_bank_bit_out)
      else $error("bank bit wrong after set then reset");
   a_split_trip: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_SPLWR ##1 op == MISU_SPLRD |=> wb_out.b == $past(regb_in, 2)
      && wb_out.acc == $past(acc_in, 2))
      else $error("split transfer round trip wrong");
   a_sw_reset: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      op == MISU_SWRST ##1 op != MISU_SWRST |-> sys_reset_req_out ##1 !sys_reset_req_out)
      else $error("software reset pulse wrong");

endmodule
`default_nettype wire

/* src/misu_map.svh */
// Opcodes, reset values and field positions of the miscellaneous system instruction unit.
// Assumes a 10-bit instruction word and 4-bit accumulator and B register.
`ifndef MISU_MAP_SVH
`define MISU_MAP_SVH

`define MISU_OP_NOP 10'h000
`define MISU_OP_SWRST 10'h001
`define MISU_OP_PWROFF 10'h002
`define MISU_OP_PUTEST 10'h003
`define MISU_OP_POFEN 10'h05b
`define MISU_OP_WDSVC 10'h2a0
`define MISU_OP_WDDIS 10'h29c
`define MISU_OP_DETEN 10'h293
`define MISU_OP_BKRST 10'h040
`define MISU_OP_BKSET 10'h041
`define MISU_OP_SPLRD 10'h278
`define MISU_OP_SPLWR 10'h238
`define MISU_OP_RDQA 10'h204
`define MISU_OP_WRQA 10'h244
`define MISU_OP_RDQB 10'h205
`define MISU_OP_WRQB 10'h245
`define MISU_OP_RDQC 10'h206
`define MISU_OP_WRQC 10'h246
`define MISU_OP_CSTART 10'h29f
`define MISU_OP_CDTEST 10'h287

`define MISU_NIB_RST 4'h0
`define MISU_SIO_RST 8'h00
`define MISU_MODE_BIT 3

`endif

/* src/misu_pkg.sv */
// Types shared by the miscellaneous system instruction unit.
// Assumes nothing of its surroundings.
package misu_pkg;
   typedef enum logic [4:0] {
      MISU_NONE, MISU_NOP, MISU_SWRST, MISU_PWROFF, MISU_PUTEST, MISU_POFEN,
      MISU_WDSVC, MISU_WDDIS, MISU_DETEN, MISU_BKRST, MISU_BKSET,
      MISU_SPLRD, MISU_SPLWR, MISU_RDQA, MISU_WRQA, MISU_RDQB, MISU_WRQB,
      MISU_RDQC, MISU_WRQC, MISU_CSTART, MISU_CDTEST
   } misu_op_t;

   // Write-back bundle to the accumulator and B register
   typedef struct packed {
      logic acc_load;
      logic [3:0] acc;
      logic b_load;
      logic [3:0] b;
   } misu_wb_t;
endpackage

/* verification/tb_misc_system_instruction_unit.sv */
// Self-checking testbench for the miscellaneous system instruction unit.
// Assumes misu_core with registered outputs that change at the taking edge itself.
`timescale 1ns/1ps
`default_nettype none
`include "misu_map.svh"

module tb_misc_system_instruction_unit import misu_pkg::*; ();
   logic mclk_in, nrst_in, instr_valid_in, conv_done_set_in, conv_irq_enable_bit_in;
   logic powerup_flag_in, watchdog_flag_one_in, backup_mode_in, detector_enable_pin_in;
   logic [9:0] instr_code_in;
   logic [3:0] acc_in, regb_in, val;
   misu_wb_t wb_out;
   logic skip_out, conv_start_out, conv_cmp_mode_out, conv_done_flag_out, power_off_req_out;
   logic watchdog_flag_clear_out, watchdog_stop_out, sys_reset_req_out, detector_active_out;
   logic table_bank_bit_out;
   logic [3:0] regs [3];
   logic [7:0] sio_out;
   int err_count, comparisons, i;

   misu_core dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
      .instr_code_in(instr_code_in), .acc_in(acc_in), .regb_in(regb_in),
      .conv_done_set_in(conv_done_set_in), .conv_irq_enable_bit_in(conv_irq_enable_bit_in),
      .powerup_flag_in(powerup_flag_in), .watchdog_flag_one_in(watchdog_flag_one_in),
      .backup_mode_in(backup_mode_in), .detector_enable_pin_in(detector_enable_pin_in),
      .wb_out(wb_out), .skip_out(skip_out), .conv_start_out(conv_start_out),
      .conv_cmp_mode_out(conv_cmp_mode_out), .conv_done_flag_out(conv_done_flag_out),
      .conv_ctrl_reg_a_out(regs[0]), .conv_ctrl_reg_b_out(regs[1]),
      .conv_ctrl_reg_c_out(regs[2]), .power_off_req_out(power_off_req_out),
      .watchdog_flag_clear_out(watchdog_flag_clear_out), .watchdog_stop_out(watchdog_stop_out),
      .sys_reset_req_out(sys_reset_req_out), .detector_active_out(detector_active_out),
      .table_bank_bit_out(table_bank_bit_out), .sio_out(sio_out));

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Present one instruction; it is taken at the next edge
   task automatic put(input logic [9:0] c, input logic [3:0] a, input logic [3:0] b);
      @(posedge mclk_in);
      instr_valid_in <= 1'b1;
      instr_code_in <= c;
      acc_in <= a;
      regb_in <= b;
   endtask

   task automatic idle;
      @(posedge mclk_in);
      instr_valid_in <= 1'b0;
   endtask

   // Single instruction, then settle into the answer cycle
   task automatic run(input logic [9:0] c, input logic [3:0] a, input logic [3:0] b);
      put(c, a, b);
      idle();
      #1;
   endtask

   task automatic setin(input logic [4:0] f);
      @(posedge mclk_in);
      {conv_irq_enable_bit_in, powerup_flag_in, watchdog_flag_one_in, backup_mode_in,
         detector_enable_pin_in} <= f;
   endtask

   task automatic set_done;
      @(posedge mclk_in);
      conv_done_set_in <= 1'b1;
      @(posedge mclk_in);
      conv_done_set_in <= 1'b0;
      #1;
   endtask

   task automatic settle;
      repeat (5) @(posedge mclk_in);
      #1;
   endtask

   initial begin
      repeat (5000) @(posedge mclk_in);
      err_count++;
      report_and_stop();
   end

   initial begin
      {nrst_in, instr_valid_in, conv_done_set_in} = 3'h0;
      {instr_code_in, acc_in, regb_in} = 18'h0;
      {conv_irq_enable_bit_in, powerup_flag_in, watchdog_flag_one_in} = 3'h0;
      {backup_mode_in, detector_enable_pin_in} = 2'h0;
      err_count = 0;
      comparisons = 0;
      repeat (3) @(posedge mclk_in);
      nrst_in <= 1'b1;
      #1;
      chk(8'({table_bank_bit_out, watchdog_stop_out}), 8'h00);
      chk(8'({detector_active_out, conv_done_flag_out}), 8'h00);
      chk(sio_out, 8'h00);
      // No-operation changes no output, though it disarms a pending two-step arming
      run(`MISU_OP_NOP, 4'hf, 4'hf);
      chk(8'({wb_out.acc_load, wb_out.b_load, skip_out, conv_start_out, power_off_req_out,
         sys_reset_req_out, watchdog_flag_clear_out}), 8'h00);
      // Converter control registers, write then read back to back
      for (i = 0; i < 3; i++) begin
         val = 4'hc - 4'(i);
         put(10'(`MISU_OP_WRQA + i), val, 4'h0);
         put(10'(`MISU_OP_RDQA + i), 4'h0, 4'h0);
         #1;
         chk({4'h0, regs[i]}, {4'h0, val});
         idle();
         #1;
         chk({3'h0, wb_out.acc_load, wb_out.acc}, {3'h0, 1'b1, val});
      end
      // Start in comparator mode with done flag set, then in conversion mode
      set_done();
      chk(8'(conv_done_flag_out), 8'h01);
      run(`MISU_OP_CSTART, 4'h0, 4'h0);
      chk(8'({conv_start_out, conv_cmp_mode_out, conv_done_flag_out}), 8'h06);
      run(`MISU_OP_WRQA, 4'h3, 4'h0);
      run(`MISU_OP_CSTART, 4'h0, 4'h0);
      chk(8'({conv_start_out, conv_cmp_mode_out}), 8'h02);
      // A converter set in the cycle of the start's clear wins
      put(`MISU_OP_CSTART, 4'h0, 4'h0);
      conv_done_set_in <= 1'b1;
      idle();
      conv_done_set_in <= 1'b0;
      #1;
      chk(8'(conv_done_flag_out), 8'h01);
      // Done-flag test with interrupt enabled, then disabled
      setin(5'b10000);
      set_done();
      run(`MISU_OP_CDTEST, 4'h0, 4'h0);
      chk(8'({skip_out, conv_done_flag_out}), 8'h01);
      setin(5'b00000);
      run(`MISU_OP_CDTEST, 4'h0, 4'h0);
      chk(8'({skip_out, conv_done_flag_out}), 8'h02);
      run(`MISU_OP_CDTEST, 4'h0, 4'h0);
      chk(8'(skip_out), 8'h00);
      // Power-up flag test
      setin(5'b01000);
      run(`MISU_OP_PUTEST, 4'h0, 4'h0);
      chk(8'(skip_out), 8'h01);
      setin(5'b00000);
      run(`MISU_OP_PUTEST, 4'h0, 4'h0);
      chk(8'(skip_out), 8'h00);
      // Power-off alone, armed, broken by unknown code, armed across idle
      run(`MISU_OP_PWROFF, 4'h0, 4'h0);
      chk(8'(power_off_req_out), 8'h00);
      put(`MISU_OP_POFEN, 4'h0, 4'h0);
      put(`MISU_OP_PWROFF, 4'h0, 4'h0);
      idle();
      #1;
      chk(8'(power_off_req_out), 8'h01);
      put(`MISU_OP_POFEN, 4'h0, 4'h0);
      put(10'h3ff, 4'h0, 4'h0);
      put(`MISU_OP_PWROFF, 4'h0, 4'h0);
      idle();
      #1;
      chk(8'(power_off_req_out), 8'h00);
      put(`MISU_OP_POFEN, 4'h0, 4'h0);
      idle();
      put(`MISU_OP_PWROFF, 4'h0, 4'h0);
      idle();
      #1;
      chk(8'(power_off_req_out), 8'h01);
      // Watchdog service with flag clear, then set, then the two-step stop
      run(`MISU_OP_WDSVC, 4'h0, 4'h0);
      chk(8'({skip_out, watchdog_flag_clear_out, watchdog_stop_out}), 8'h00);
      setin(5'b00100);
      run(`MISU_OP_WDSVC, 4'h0, 4'h0);
      chk(8'({skip_out, watchdog_flag_clear_out, watchdog_stop_out}), 8'h06);
      run(`MISU_OP_WDDIS, 4'h0, 4'h0);
      run(`MISU_OP_NOP, 4'h0, 4'h0);
      chk(8'(watchdog_stop_out), 8'h00);
      put(`MISU_OP_WDDIS, 4'h0, 4'h0);
      put(`MISU_OP_NOP, 4'h0, 4'h0);
      put(`MISU_OP_WDSVC, 4'h0, 4'h0);
      idle();
      #1;
      chk(8'(watchdog_stop_out), 8'h00);
      put(`MISU_OP_WDDIS, 4'h0, 4'h0);
      put(`MISU_OP_WDSVC, 4'h0, 4'h0);
      idle();
      #1;
      chk(8'({skip_out, watchdog_flag_clear_out}), 8'h03);
      settle();
      chk(8'(watchdog_stop_out), 8'h01);
      // Detector: needs enable, back-up and pin high together
      setin(5'b00011);
      settle();
      chk(8'(detector_active_out), 8'h00);
      run(`MISU_OP_DETEN, 4'h0, 4'h0);
      settle();
      chk(8'(detector_active_out), 8'h01);
      setin(5'b00010);
      settle();
      chk(8'(detector_active_out), 8'h00);
      setin(5'b00001);
      settle();
      chk(8'(detector_active_out), 8'h00);
      // Table bank select, set then reset back to back
      put(`MISU_OP_BKSET, 4'h0, 4'h0);
      put(`MISU_OP_BKRST, 4'h0, 4'h0);
      #1;
      chk(8'(table_bank_bit_out), 8'h01);
      idle();
      #1;
      chk(8'(table_bank_bit_out), 8'h00);
      // Split write, then write and read back to back
      run(`MISU_OP_SPLWR, 4'h5, 4'ha);
      chk(sio_out, 8'ha5);
      put(`MISU_OP_SPLWR, 4'hc, 4'h3);
      put(`MISU_OP_SPLRD, 4'h0, 4'h0);
      idle();
      #1;
      chk({wb_out.b, wb_out.acc}, 8'h3c);
      chk(8'({wb_out.b_load, wb_out.acc_load}), 8'h03);
      // Software reset pulses for one cycle
      run(`MISU_OP_SWRST, 4'h0, 4'h0);
      chk(8'(sys_reset_req_out), 8'h01);
      @(posedge mclk_in);
      #1;
      chk(8'(sys_reset_req_out), 8'h00);
      // Reset in mid-run clears the sticky stop and the transfer register
      @(posedge mclk_in);
      nrst_in <= 1'b0;
      @(posedge mclk_in);
      nrst_in <= 1'b1;
      #1;
      chk(8'({watchdog_stop_out, table_bank_bit_out}), 8'h00);
      chk(sio_out, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
